// [src/rx_recovery_pkg.sv]
/*
 * Shared types and constants of the serial receive front end.
 * Assumes a single system clock domain and no software register map.
 */
package rx_recovery_pkg;

	// ----------------------------------------------------------------
	// Oversampling and voting
	// ----------------------------------------------------------------
	localparam logic [4:0] SAMPLES_NORMAL    = 5'h10;
	localparam logic [4:0] SAMPLES_DOUBLE    = 5'h08;
	localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [4:0] VOTE_SPAN         = 5'h02;

	// ----------------------------------------------------------------
	// Frame format
	// ----------------------------------------------------------------
	localparam logic [3:0] FRAME_BITS_MIN = 4'h5;
	localparam logic [3:0] FRAME_BITS_MAX = 4'hA;
	localparam int         FRAME_BITS_W   = 10;

	// ----------------------------------------------------------------
	// Divider, buffer and reset values
	// ----------------------------------------------------------------
	localparam int          DIVISOR_W     = 12;
	localparam logic [11:0] DIVISOR_RESET = 12'h000;
	localparam logic        LINE_IDLE     = 1'b1;
	localparam int          FIFO_DEPTH    = 8;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_HUNT  = 2'b01,
		ST_START = 2'b10,
		ST_DATA  = 2'b11
	} rx_state_t;

	typedef struct packed {
		logic [FRAME_BITS_W-1:0] bits;
		logic                    frame_error_flag;
	} frame_t;

	localparam int FRAME_W = $bits(frame_t);

endpackage

// [src/rx_frame_fifo.sv]
/*
 * Flip-flop FIFO with valid/ready on both sides and a synchronous flush.
 * Assumes the writer honours in_ready and the reader honours out_valid.
 */
module rx_frame_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_r;
	logic [PW-1:0]    rd_r;
	logic [PW:0]      count_r;
	logic             push_w;
	logic             pop_w;

	assign in_ready  = (count_r != (PW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_r];
	assign push_w    = in_valid && in_ready;
	assign pop_w     = out_valid && out_ready;

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (push_w)
			mem_r[wr_r] <= in_data;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_r    <= '0;
			rd_r    <= '0;
			count_r <= '0;
		end else if (flush) begin
			wr_r    <= '0;
			rd_r    <= '0;
			count_r <= '0;
		end else begin
			if (push_w)
				wr_r <= (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + PW'(1);
			if (pop_w)
				rd_r <= (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + PW'(1);
			count_r <= count_r + (PW+1)'(push_w) - (PW+1)'(pop_w);
		end
	end

	fifo_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
		count_r <= (PW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

// [src/uart_rx_recovery.sv]
/*
 * Receive clock and data recovery: synchroniser, oversampling divider,
 * start-bit qualification, majority-vote bit recovery and frame buffer.
 * Assumes a remote asynchronous transmitter on RXD, a static frame
 * format while enabled, and a consumer draining the OUT_* stream.
 */
// Overview of operation
// R1: The line is sampled at sixteen ticks per bit, or eight in double speed.
// R2: A high-to-low edge from idle starts qualification and its first low sample is number one.
// R3: The start bit is judged by majority over samples 8-10, or 4-6 in double speed.
// R4: A start bit voted high is dropped as noise and the edge search resumes.
// R5: A qualified start bit realigns the sample counter and data recovery begins, every frame.
// R6: Each bit walks a sample counter of sixteen states, or eight in double speed; the code ends the stop bit at its last voting sample instead.
// R7: Data, parity and stop bits are decided from the three centre samples.
// R8: Two or three high samples give one, two or three low samples give zero.
// R9: Recovery ends with the first stop bit and later stop bits are ignored.
// R10: A first stop bit voted low sets the frame error flag of that frame.
// R11: A new start edge is accepted from the second tick after the last stop-bit voting sample, once a high line has been seen.
// R12: The data-plus-parity count may be anything from five to ten bits.
// R13: The remote transmitter must keep its bit rate inside the receiver tolerance window.
// R14: Double speed divides by eight instead of sixteen, doubling the bit rate.
// R15: Clearing the receiver enable abandons any frame at once.
// R16: The serial input is synchronised to the system clock before any use.
// R17: After any frame end the receiver waits for a high line before hunting an edge.
module uart_rx_recovery (
	input  wire logic                   CLK,
	input  wire logic                   ARST_N,
	input  wire logic                   RXD,
	input  wire logic                   RECEIVER_ENABLE_BIT,
	input  wire logic                   DOUBLE_SPEED_SELECT,
	input  wire logic [11:0]            BAUD_DIVISOR_VALUE,
	input  wire logic [3:0]             FRAME_BITS,
	output logic                        RX_ACTIVE,
	output logic                        OUT_VALID,
	input  wire logic                   OUT_READY,
	output rx_recovery_pkg::frame_t     OUT_DATA
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic maj3(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	function automatic logic [3:0] clamp_len(input logic [3:0] n);
		if (n < rx_recovery_pkg::FRAME_BITS_MIN)
			return rx_recovery_pkg::FRAME_BITS_MIN;
		if (n > rx_recovery_pkg::FRAME_BITS_MAX)
			return rx_recovery_pkg::FRAME_BITS_MAX;
		return n;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic                       s1_r;
	logic                       s2_r;
	logic                       s3_r;
	logic                       line_r;
	logic [11:0]                div_r;
	logic [11:0]                div_nxt;
	logic                       tick_w;
	rx_recovery_pkg::rx_state_t state_r;
	rx_recovery_pkg::rx_state_t state_nxt;
	logic [4:0]                 samp_r;
	logic [4:0]                 samp_nxt;
	logic [3:0]                 bit_r;
	logic [3:0]                 bit_nxt;
	logic [1:0]                 vote_r;
	logic [1:0]                 vote_nxt;
	logic [9:0]                 bits_r;
	logic [9:0]                 bits_nxt;
	logic                       push_r;
	logic                       push_nxt;
	rx_recovery_pkg::frame_t    pdata_r;
	rx_recovery_pkg::frame_t    pdata_nxt;
	logic [4:0]                 spb_w;
	logic [4:0]                 first_w;
	logic [4:0]                 last_w;
	logic [4:0]                 cnt_w;
	logic                       in_win_w;
	logic                       voted_w;
	logic [3:0]                 len_w;
	logic                       fifo_ready_w;
	logic [rx_recovery_pkg::FRAME_W-1:0] fifo_out_w;

	// ----------------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s1_r   <= rx_recovery_pkg::LINE_IDLE;
			s2_r   <= rx_recovery_pkg::LINE_IDLE;
			s3_r   <= rx_recovery_pkg::LINE_IDLE;
			line_r <= rx_recovery_pkg::LINE_IDLE;
		end else begin
			s1_r <= RXD;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				line_r <= s3_r; // R16
		end
	end

	// ----------------------------------------------------------------
	// Oversampling divider
	// ----------------------------------------------------------------
	assign tick_w  = RECEIVER_ENABLE_BIT && (div_r == 12'h000);
	assign div_nxt = (!RECEIVER_ENABLE_BIT || div_r == 12'h000) ?
		BAUD_DIVISOR_VALUE : div_r - 12'h001;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			div_r <= rx_recovery_pkg::DIVISOR_RESET;
		else
			div_r <= div_nxt;
	end

	// ----------------------------------------------------------------
	// Sample decode
	// ----------------------------------------------------------------
	assign spb_w    = DOUBLE_SPEED_SELECT ? rx_recovery_pkg::SAMPLES_DOUBLE :
		rx_recovery_pkg::SAMPLES_NORMAL; // R1 R6 R14
	assign first_w  = DOUBLE_SPEED_SELECT ? rx_recovery_pkg::VOTE_FIRST_DOUBLE :
		rx_recovery_pkg::VOTE_FIRST_NORMAL;
	assign last_w   = first_w + rx_recovery_pkg::VOTE_SPAN;
	assign cnt_w    = samp_r + 5'h01;
	assign in_win_w = (cnt_w >= first_w) && (cnt_w <= last_w); // R3 R7
	assign voted_w  = maj3({vote_r, line_r}); // R8
	assign len_w    = clamp_len(FRAME_BITS); // R12

	// ----------------------------------------------------------------
	// Recovery state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		samp_nxt  = samp_r;
		bit_nxt   = bit_r;
		vote_nxt  = vote_r;
		bits_nxt  = bits_r;
		push_nxt  = 1'b0;
		pdata_nxt = pdata_r;
		if (!RECEIVER_ENABLE_BIT) begin
			state_nxt = rx_recovery_pkg::ST_IDLE; // R15
		end else if (tick_w) begin
			case (state_r)
			rx_recovery_pkg::ST_IDLE: begin
				if (line_r)
					state_nxt = rx_recovery_pkg::ST_HUNT; // R17
			end
			rx_recovery_pkg::ST_HUNT: begin
				// A full buffer holds off new frames
				if (!line_r && fifo_ready_w) begin
					state_nxt = rx_recovery_pkg::ST_START; // R2
					samp_nxt  = 5'h01;
					bit_nxt   = 4'h0;
					bits_nxt  = 10'h000;
				end
			end
			rx_recovery_pkg::ST_START: begin
				samp_nxt = cnt_w;
				if (in_win_w)
					vote_nxt = {vote_r[0], line_r};
				if (cnt_w == last_w && voted_w) begin
					state_nxt = rx_recovery_pkg::ST_IDLE; // R4
				end else if (cnt_w == spb_w) begin
					state_nxt = rx_recovery_pkg::ST_DATA; // R5
					samp_nxt  = 5'h00;
					bit_nxt   = 4'h0;
				end
			end
			rx_recovery_pkg::ST_DATA: begin
				samp_nxt = cnt_w;
				if (in_win_w)
					vote_nxt = {vote_r[0], line_r};
				if (cnt_w == last_w) begin
					if (bit_r == len_w) begin
						state_nxt = rx_recovery_pkg::ST_IDLE; // R9 R11
						push_nxt  = 1'b1;
						pdata_nxt = '{bits: bits_r, frame_error_flag: !voted_w}; // R10
					end else begin
						bits_nxt[bit_r] = voted_w; // R7
					end
				end
				if (cnt_w == spb_w) begin
					samp_nxt = 5'h00;
					bit_nxt  = bit_r + 4'h1;
				end
			end
			default: state_nxt = rx_recovery_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r <= rx_recovery_pkg::ST_IDLE;
			samp_r  <= 5'h00;
			bit_r   <= 4'h0;
			vote_r  <= 2'h0;
			bits_r  <= 10'h000;
			push_r  <= 1'b0;
			pdata_r <= '0;
		end else begin
			state_r <= state_nxt;
			samp_r  <= samp_nxt;
			bit_r   <= bit_nxt;
			vote_r  <= vote_nxt;
			bits_r  <= bits_nxt;
			push_r  <= push_nxt;
			pdata_r <= pdata_nxt;
		end
	end

	assign RX_ACTIVE = (state_r == rx_recovery_pkg::ST_START) ||
		(state_r == rx_recovery_pkg::ST_DATA);

	// ----------------------------------------------------------------
	// Frame buffer
	// ----------------------------------------------------------------
	rx_frame_fifo #(
		.WIDTH (rx_recovery_pkg::FRAME_W),
		.DEPTH (rx_recovery_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.arst_n    (ARST_N),
		.flush     (!RECEIVER_ENABLE_BIT),
		.in_valid  (push_r),
		.in_ready  (fifo_ready_w),
		.in_data   (pdata_r),
		.out_valid (OUT_VALID),
		.out_ready (OUT_READY),
		.out_data  (fifo_out_w)
	);

	assign OUT_DATA = rx_recovery_pkg::frame_t'(fifo_out_w);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking

	default disable iff (!ARST_N);

	sync_agree_a: assert property ( // R16
		$changed(line_r) |-> ($past(s2_r) == $past(s3_r)) && (line_r == $past(s3_r)))
		else $error("line level changed without agreeing stages");

	edge_start_a: assert property ( // R2
		state_r == rx_recovery_pkg::ST_HUNT && tick_w && !line_r && fifo_ready_w
		|=> state_r == rx_recovery_pkg::ST_START && samp_r == 5'h01)
		else $error("falling edge did not begin start qualification");

	start_reject_a: assert property ( // R4
		state_r == rx_recovery_pkg::ST_START && tick_w && cnt_w == last_w && voted_w
		|=> state_r == rx_recovery_pkg::ST_IDLE)
		else $error("noise start bit was not rejected");

	start_align_a: assert property ( // R5
		state_r == rx_recovery_pkg::ST_START && tick_w && cnt_w == spb_w
		|=> state_r == rx_recovery_pkg::ST_DATA && samp_r == 5'h00 && bit_r == 4'h0)
		else $error("data recovery not aligned to start bit");

	sample_range_a: assert property ( // R1
		state_r == rx_recovery_pkg::ST_DATA |-> samp_r < spb_w)
		else $error("sample counter beyond bit length");

	bit_vote_a: assert property ( // R8
		state_r == rx_recovery_pkg::ST_DATA && tick_w && cnt_w == last_w && bit_r != len_w
		|=> bits_r[$past(bit_r)] == $past(voted_w))
		else $error("recovered bit differs from majority");

	stop_error_a: assert property ( // R10
		state_r == rx_recovery_pkg::ST_DATA && tick_w && cnt_w == last_w && bit_r == len_w
		|=> push_r && pdata_r.frame_error_flag == !$past(voted_w)
			&& state_r == rx_recovery_pkg::ST_IDLE)
		else $error("stop bit handling wrong");

	disable_abort_a: assert property ( // R15
		!RECEIVER_ENABLE_BIT |=> state_r == rx_recovery_pkg::ST_IDLE && !OUT_VALID)
		else $error("disable did not abandon reception");

	idle_wait_a: assert property ( // R17
		state_r == rx_recovery_pkg::ST_IDLE && !line_r |=> state_r != rx_recovery_pkg::ST_START)
		else $error("edge accepted without high line");

	len_range_a: assert property ( // R12
		RX_ACTIVE |-> bit_r <= len_w && len_w >= rx_recovery_pkg::FRAME_BITS_MIN)
		else $error("bit index beyond frame length");

	frame_clear_a: assert property ( // R5
		state_r == rx_recovery_pkg::ST_HUNT && tick_w && !line_r && fifo_ready_w
		|=> bits_r == 10'h000 && bit_r == 4'h0)
		else $error("frame state not cleared at start edge");

	good_frame_c: cover property (push_r && !pdata_r.frame_error_flag);
	bad_frame_c: cover property (push_r && pdata_r.frame_error_flag);
	noise_reject_c: cover property (
		state_r == rx_recovery_pkg::ST_START ##1 state_r == rx_recovery_pkg::ST_IDLE);
	fifo_full_c: cover property (!fifo_ready_w);
	double_frame_c: cover property (push_r && DOUBLE_SPEED_SELECT);

endmodule

// [bench/tx_line_model.sv]
/*
 * Behavioural model of the remote serial transmitter that drives the line.
 * Assumes the caller gives bit periods in CLK cycles that suit the receiver.
 */
module tx_line_model (
	input  wire logic CLK,
	output logic      TXD
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------
	// Line driving
	// ------------------------------------------------
	initial TXD = 1'b1;

	// Holds a level for n cycles, n of two or more
	task automatic hold(input logic v, input int n);
		@(posedge CLK);
		#1 TXD = v;
		repeat (n - 1) @(posedge CLK);
	endtask

	// Low pulse, then back to the idle high level
	task automatic pulse_low(input int n);
		hold(1'b0, n);
		#1 TXD = 1'b1;
	endtask

	// Start bit, bits LSB first at an exact rate, one stop bit
	task automatic send(input logic [9:0] d, input int nb, input logic stop,
			input int per, input int stop_len);
		hold(1'b0, per);
		for (int i = 0; i < nb; i++)
			hold(d[i], per);
		hold(stop, stop_len);
		#1 TXD = 1'b1;
	endtask
endmodule

// [bench/uart_rx_clock_data_recovery_tb_top.sv]
/*
 * Self-checking bench of the receive recovery block with a line model.
 * Assumes a divisor of 3: one tick every 4 CLK, 64 CLK a bit at normal speed.
 */
module uart_rx_clock_data_recovery_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic                    CLK = 1'b0;
	logic                    ARST_N = 1'b0;
	wire logic               rxd;
	logic                    en = 1'b0;
	logic                    dbl = 1'b0;
	logic [11:0]             div = 12'h003;
	logic [3:0]              fbits = 4'h8;
	logic                    ready = 1'b0;
	logic                    active;
	logic                    valid;
	rx_recovery_pkg::frame_t data;
	int                      bad_count = 0;
	int                      n_checks = 0;

	always #5 CLK = ~CLK;

	tx_line_model tx (.CLK(CLK), .TXD(rxd));

	uart_rx_recovery uut (
		.CLK(CLK), .ARST_N(ARST_N), .RXD(rxd), .RECEIVER_ENABLE_BIT(en),
		.DOUBLE_SPEED_SELECT(dbl), .BAUD_DIVISOR_VALUE(div), .FRAME_BITS(fbits),
		.RX_ACTIVE(active), .OUT_VALID(valid), .OUT_READY(ready), .OUT_DATA(data)
	);

	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic step();
		@(posedge CLK);
		#1;
	endtask

	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [10:0] word(input logic [9:0] d, input int nb, input logic fe);
		return {d & (10'h3FF >> (10 - nb)), fe};
	endfunction

	// Waits for a buffered word, compares it and pops it
	task automatic pop(input logic [10:0] exp);
		int i;
		for (i = 0; i < 3000 && valid !== 1'b1; i++)
			step();
		if (i == 3000) begin
			bad_count++;
			tally_and_finish();
		end
		check(data, exp);
		ready = 1'b1;
		step();
		ready = 1'b0;
		step();
	endtask

	// Format changes only while the receiver is off
	task automatic setup(input logic d, input logic [3:0] nb);
		en = 1'b0;
		step();
		dbl = d;
		fbits = nb;
		en = 1'b1;
		repeat (20) step();
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_basic();
		setup(1'b0, 4'h8);
		tx.send(10'h0A5, 8, 1'b1, 64, 64);
		pop(word(10'h0A5, 8, 1'b0));
		tx.send(10'h03C, 8, 1'b0, 64, 64);
		pop(word(10'h03C, 8, 1'b1));
		// Line back to idle high after the low stop bit
		repeat (16) step();
		tx.send(10'h0C5, 8, 1'b1, 64, 64);
		pop(word(10'h0C5, 8, 1'b0));
	endtask

	task automatic t_double();
		setup(1'b1, 4'h8);
		tx.send(10'h05A, 8, 1'b1, 32, 32);
		pop(word(10'h05A, 8, 1'b0));
		tx.send(10'h0F0, 8, 1'b0, 32, 32);
		pop(word(10'h0F0, 8, 1'b1));
	endtask

	task automatic t_width();
		for (int nb = 5; nb <= 10; nb++) begin
			setup(1'b0, 4'(nb));
			tx.send(10'h2B5, nb, 1'b1, 64, 64);
			pop(word(10'h2B5, nb, 1'b0));
		end
		// Out-of-range length is clamped to ten bits
		setup(1'b0, 4'hF);
		tx.send(10'h2B5, 10, 1'b1, 64, 64);
		pop(word(10'h2B5, 10, 1'b0));
	endtask

	task automatic t_noise();
		setup(1'b0, 4'h8);
		tx.pulse_low(20);
		check({10'h000, active}, 11'h001);
		repeat (80) step();
		check({10'h000, active}, 11'h000);
		check({10'h000, valid}, 11'h000);
		tx.send(10'h081, 8, 1'b1, 64, 64);
		pop(word(10'h081, 8, 1'b0));
	endtask

	task automatic t_b2b();
		setup(1'b0, 4'h8);
		tx.send(10'h03C, 8, 1'b1, 64, 52);
		tx.send(10'h0C3, 8, 1'b1, 64, 52);
		tx.send(10'h099, 8, 1'b1, 64, 64);
		pop(word(10'h03C, 8, 1'b0));
		pop(word(10'h0C3, 8, 1'b0));
		pop(word(10'h099, 8, 1'b0));
	endtask

	// Fills the buffer, a ninth frame is refused, then drains it
	task automatic t_full();
		setup(1'b0, 4'h8);
		for (int i = 0; i < 9; i++)
			tx.send(10'(8'h10 + i), 8, 1'b1, 64, 64);
		for (int i = 0; i < 8; i++)
			pop(word(10'(8'h10 + i), 8, 1'b0));
		repeat (8) step();
		check({10'h000, valid}, 11'h000);
	endtask

	task automatic t_abort();
		setup(1'b0, 4'h8);
		tx.send(10'h0C3, 8, 1'b1, 64, 64);
		repeat (100) step();
		check({10'h000, valid}, 11'h001);
		fork
			tx.send(10'h0FF, 8, 1'b1, 64, 64);
		join_none
		repeat (200) step();
		check({10'h000, active}, 11'h001);
		en = 1'b0;
		step();
		check({10'h000, active}, 11'h000);
		check({10'h000, valid}, 11'h000);
		wait fork;
		setup(1'b0, 4'h8);
		tx.send(10'h066, 8, 1'b1, 64, 64);
		pop(word(10'h066, 8, 1'b0));
		repeat (8) step();
		check({10'h000, valid}, 11'h000);
	endtask

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		repeat (4) @(posedge CLK);
		#1 ARST_N = 1'b1;
		t_basic();
		t_double();
		t_width();
		t_noise();
		t_b2b();
		t_full();
		t_abort();
		tally_and_finish();
	end
endmodule
